//--- hw/ppm_pkg.sv
// ============================================================
// Shared constants and types
// ============================================================
package ppm_pkg;

  localparam int unsigned ADR_WIDTH       = 12;
  localparam logic [9:0]  IDX_CONTROL     = 10'h0D7;
  localparam logic [9:0]  IDX_SAMPLE      = 10'h0D8;
  localparam logic [9:0]  IDX_STATUS      = 10'h0D9;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;
  localparam logic [7:0]  SAMPLE_RESET    = 8'h00;
  localparam logic [7:0]  CONTROL_RW_MASK = 8'hED;
  localparam logic [1:0]  PRESC_DIV4      = 2'h0;
  localparam logic [1:0]  PRESC_DIV6      = 2'h1;
  localparam logic [1:0]  PRESC_DIV7      = 2'h2;
  localparam logic [2:0]  DIVISOR_4       = 3'h4;
  localparam logic [2:0]  DIVISOR_6       = 3'h6;
  localparam logic [2:0]  DIVISOR_7       = 3'h7;
  localparam int unsigned PERIOD_COUNTS   = 128;
  localparam logic [6:0]  PERIOD_LAST     = 7'h7F;

  // ============================================================
  // Register layouts
  // ============================================================
  typedef struct packed {
    logic [1:0] low_bits;
    logic       wide_sample_select;
    logic       rsv4;
    logic [1:0] presc;
    logic       rsv1;
    logic       on;
  } ppm_ctl_t;

  typedef struct packed {
    logic [6:0] period_pos;
    logic       running;
  } ppm_status_t;

  // Settings that one sample period runs with.
  typedef struct packed {
    logic       sign;
    logic       wide;
    logic [1:0] presc;
    logic [8:0] mag;
  } ppm_cfg_t;

  typedef struct packed {
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [ADR_WIDTH-1:0] adr;
    logic [3:0]           sel;
    logic [31:0]          dat;
  } ppm_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ppm_wb_rsp_t;

  typedef enum logic [1:0] {
    PPM_IDLE = 2'b01,
    PPM_RUN  = 2'b10
  } ppm_state_t;

  function automatic logic [2:0] ppm_divisor(input logic [1:0] code);
    case (code)
      PRESC_DIV4: return DIVISOR_4;
      PRESC_DIV6: return DIVISOR_6;
      default:    return DIVISOR_7;
    endcase
  endfunction : ppm_divisor

endpackage : ppm_pkg

//--- hw/ppm_tick_gen.sv
`timescale 1ns/100ps
// ============================================================
// Prescaler and counter clock enables
// ============================================================
module ppm_tick_gen (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       ce,
  input  wire logic       hold,
  input  wire logic       restart,
  input  wire logic [1:0] presc,
  input  wire logic       wide,
  output logic            period_tick,
  output logic            data_tick
);

  logic [2:0] pre_q;
  logic       half_q;
  logic [2:0] div;

  always_comb begin
    div         = ppm_pkg::ppm_divisor(presc); // [R19]
    period_tick = !hold && (pre_q == div - 3'h1); // [R9]
    if (hold) begin
      data_tick = 1'b0;
    end else if (!wide) begin
      data_tick = period_tick; // [R9]
    end else if (presc == ppm_pkg::PRESC_DIV4) begin
      data_tick = 1'b1; // [R12]
    end else begin
      data_tick = half_q; // [R12]
    end
  end

  // Both counters restart with the period, so the odd divide by 7
  // never leaves the half-rate phase misaligned.
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_q <= 3'h0;
    end else if (ce) begin
      if (hold || restart || period_tick) begin
        pre_q <= 3'h0;
      end else begin
        pre_q <= pre_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      half_q <= 1'b0;
    end else if (ce) begin
      half_q <= (hold || restart) ? 1'b0 : !half_q;
    end
  end

endmodule : ppm_tick_gen

//--- hw/ppm_modulator.sv
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/100ps
// ============================================================
// Summary of operation
// [R1] Sample sign bit picks which output pulses; the other stays low.
// [R2] A zero magnitude keeps both outputs low all period.
// [R3] While on, periods repeat with the current settings indefinitely.
// [R4] Control: bit0 on, bits3:2 prescaler, bit5 width, bits7:6 low bits.
// [R5] Width select resets to 8-bit; setting it gives 10-bit samples.
// [R6] 10-bit magnitude appends control bits 7:6 below the sample.
// [R7] A written sample reaches the outputs one period later.
// [R8] Period counter is 128 prescaled counts; wrap restarts modulator.
// [R9] Prescaler divides by 4, 6 or 7; 8-bit mode counts both with it.
// [R10] Selected output high from period start for magnitude counts.
// [R11] 8-bit value 7FH gives full scale at every prescaler.
// [R12] 10-bit pulse counter runs at core/2, or core for divide 4.
// [R13] Only divide 4 gives the full 512 magnitude range.
// [R14] Magnitude beyond the period saturates to high all period.
// [R15] When off, both outputs are released, pulled up outside.
// [R16] Firmware turns the modulator off before chip power-down.
// [R17] Firmware writes samples in step with the sample period.
// [R18] With 10-bit and divide 7, firmware scales to +/-447.
// [R19] Prescaler codes 00, 01, 10 mean 4, 6, 7; 11 means 7.
// [R20] Magnitude is bits below the sign, latched at each restart.
// ============================================================
module ppm_modulator (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 ce,
  input  wire ppm_pkg::ppm_wb_req_t wb_req,
  output ppm_pkg::ppm_wb_rsp_t      wb_rsp,
  output logic                      positive_pulse_out,
  output logic                      positive_pulse_oe,
  output logic                      negative_pulse_out,
  output logic                      negative_pulse_oe
);

  // ============================================================
  // Declarations
  // ============================================================
  ppm_pkg::ppm_ctl_t    ctl_q;
  logic [7:0]           sample_q;
  logic                 ack_q;
  logic [31:0]          rdat_q;
  logic [7:0]           rd_byte;
  ppm_pkg::ppm_status_t status;
  logic                 bus_req;
  logic                 wr_en;
  ppm_pkg::ppm_state_t  state_q;
  ppm_pkg::ppm_cfg_t    cfg_q;
  ppm_pkg::ppm_cfg_t    cfg_d;
  ppm_pkg::ppm_cfg_t    cfg_n;
  logic [6:0]           pcnt_q;
  logic [9:0]           dcnt_q;
  logic [9:0]           dcnt_d;
  logic                 period_tick;
  logic                 data_tick;
  logic                 start;
  logic                 wrap;
  logic                 restart;
  logic                 running;
  logic                 high_d;
  logic                 pos_q;
  logic                 neg_q;
  logic                 oe_q;
  logic [9:0]           len_q;
  logic [9:0]           hi_q;
  logic                 full_q;

  function automatic logic reg_hit(input logic [11:0] adr,
                                   input logic [9:0]  idx);
    return adr[11:2] == idx;
  endfunction : reg_hit

  // ============================================================
  // Wishbone slave
  // ============================================================
  // One wait state: ack follows the request by one edge and drops
  // in the cycle after, so a held strobe is answered again every second cycle.
  assign bus_req = wb_req.cyc && wb_req.stb;
  assign wr_en   = bus_req && wb_req.we && ack_q && wb_req.sel[0];

  always_ff @(posedge clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= bus_req && !ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_q <= ppm_pkg::ppm_ctl_t'(ppm_pkg::CONTROL_RESET); // [R5]
    end else if (ce && wr_en && reg_hit(wb_req.adr,
                                        ppm_pkg::IDX_CONTROL)) begin
      ctl_q <= ppm_pkg::ppm_ctl_t'(wb_req.dat[7:0] &
                                   ppm_pkg::CONTROL_RW_MASK); // [R4]
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sample_q <= ppm_pkg::SAMPLE_RESET;
    end else if (ce && wr_en && reg_hit(wb_req.adr,
                                        ppm_pkg::IDX_SAMPLE)) begin
      sample_q <= wb_req.dat[7:0];
    end
  end

  always_comb begin
    status.period_pos = pcnt_q;
    status.running    = running;
    rd_byte           = 8'h00;
    if (reg_hit(wb_req.adr, ppm_pkg::IDX_CONTROL)) begin
      rd_byte = ctl_q;
    end else if (reg_hit(wb_req.adr, ppm_pkg::IDX_SAMPLE)) begin
      rd_byte = sample_q;
    end else if (reg_hit(wb_req.adr, ppm_pkg::IDX_STATUS)) begin
      rd_byte = status;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdat_q <= 32'h00000000;
    end else if (ce && bus_req && !ack_q) begin
      rdat_q <= {24'h000000, rd_byte};
    end
  end

  assign wb_rsp.ack = ack_q;
  assign wb_rsp.dat = rdat_q;

  // ============================================================
  // On/off control
  // ============================================================
  assign running = (state_q == ppm_pkg::PPM_RUN);

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ppm_pkg::PPM_IDLE;
    end else if (ce) begin
      case (state_q)
        ppm_pkg::PPM_IDLE: begin
          if (ctl_q.on) begin
            state_q <= ppm_pkg::PPM_RUN;
          end
        end
        ppm_pkg::PPM_RUN: begin
          if (!ctl_q.on) begin
            state_q <= ppm_pkg::PPM_IDLE; // [R15]
          end
        end
        default: begin
          state_q <= ppm_pkg::PPM_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Period timing
  // ============================================================
  ppm_tick_gen u_ticks (
    .clk         (clk),
    .reset       (reset),
    .ce          (ce),
    .hold        (!running),
    .restart     (restart),
    .presc       (cfg_q.presc),
    .wide        (cfg_q.wide),
    .period_tick (period_tick),
    .data_tick   (data_tick)
  );

  assign start   = !running && ctl_q.on;
  assign wrap    = running && ctl_q.on && period_tick &&
                   (pcnt_q == ppm_pkg::PERIOD_LAST); // [R8]
  assign restart = start || wrap; // [R3]

  always_ff @(posedge clk) begin
    if (reset) begin
      pcnt_q <= 7'h00;
    end else if (ce) begin
      if (!running || restart) begin
        pcnt_q <= 7'h00;
      end else if (period_tick) begin
        pcnt_q <= pcnt_q + 7'h01;
      end
    end
  end

  // Settings are captured only at a restart, so a write shows up in
  // the following period and never splits a pulse.
  always_comb begin
    cfg_d.sign  = sample_q[7]; // [R1]
    cfg_d.wide  = ctl_q.wide_sample_select; // [R5]
    cfg_d.presc = ctl_q.presc;
    if (ctl_q.wide_sample_select) begin
      cfg_d.mag = {sample_q[6:0], ctl_q.low_bits}; // [R6]
    end else begin
      cfg_d.mag = {2'b00, sample_q[6:0]}; // [R20]
    end
    cfg_n = restart ? cfg_d : cfg_q; // [R7]
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_q <= '0;
    end else if (ce && restart) begin
      cfg_q <= cfg_d; // [R20]
    end
  end

  always_comb begin
    if (!ctl_q.on || restart) begin
      dcnt_d = 10'h000;
    end else if (data_tick && dcnt_q != 10'h3FF) begin
      dcnt_d = dcnt_q + 10'h001; // [R14]
    end else begin
      dcnt_d = dcnt_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dcnt_q <= 10'h000;
    end else if (ce) begin
      dcnt_q <= dcnt_d;
    end
  end

  // ============================================================
  // Output drivers
  // ============================================================
  // A magnitude above the counts left in the period is simply never
  // reached by the counter, which gives saturation, not wrap.
  assign high_d = ctl_q.on && (cfg_n.mag > dcnt_d); // [R10] [R13]

  always_ff @(posedge clk) begin
    if (reset) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
      oe_q  <= 1'b0;
    end else if (ce) begin
      pos_q <= high_d && !cfg_n.sign; // [R1] [R2]
      neg_q <= high_d && cfg_n.sign; // [R1] [R2]
      oe_q  <= ctl_q.on; // [R15]
    end
  end

  assign positive_pulse_out = pos_q;
  assign negative_pulse_out = neg_q;
  assign positive_pulse_oe  = oe_q;
  assign negative_pulse_oe  = oe_q;

  // ============================================================
  // Checks
  // ============================================================
  function automatic logic [9:0] hi_expect(input ppm_pkg::ppm_cfg_t c);
    int unsigned dv;
    int unsigned unit;
    int unsigned span;
    int unsigned prod;
    dv   = int'(ppm_pkg::ppm_divisor(c.presc));
    span = ppm_pkg::PERIOD_COUNTS * dv;
    if (!c.wide) begin
      unit = dv;
    end else if (c.presc == ppm_pkg::PRESC_DIV4) begin
      unit = 1;
    end else begin
      unit = 2;
    end
    prod = int'(c.mag) * unit;
    return 10'((prod > span) ? span : prod);
  endfunction : hi_expect

  always_ff @(posedge clk) begin
    if (reset) begin
      len_q  <= 10'h000;
      hi_q   <= 10'h000;
      full_q <= 1'b0;
    end else if (ce) begin
      len_q  <= restart ? 10'h000 : len_q + 10'h001;
      hi_q   <= restart ? 10'h000 : hi_q + {9'h000, pos_q || neg_q};
      full_q <= restart || (running && ctl_q.on && full_q);
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_SIGN_PICKS_OUTPUT: assert property ( // [R1]
    cfg_q.sign ? !pos_q : !neg_q
  ) else $error("Output opposite to the sign pulsed.");

  AST_ZERO_BOTH_LOW: assert property ( // [R2]
    (cfg_q.mag == 9'h000) |-> (!pos_q && !neg_q)
  ) else $error("Zero sample drove an output high.");

  AST_KEEPS_RUNNING: assert property ( // [R3]
    (running && ctl_q.on && full_q) |-> (len_q < 10'd896)
  ) else $error("Period did not restart on its own.");

  AST_CTL_WRITE: assert property ( // [R4]
    (ce && wr_en && reg_hit(wb_req.adr, ppm_pkg::IDX_CONTROL)) |=>
      (ctl_q == ($past(wb_req.dat[7:0]) & ppm_pkg::CONTROL_RW_MASK))
  ) else $error("Control write did not land in its fields.");

  AST_WIDE_RESET: assert property ( // [R5]
    $past(reset) |-> (!ctl_q.wide_sample_select && !oe_q)
  ) else $error("Width select not cleared by reset.");

  AST_WIDE_MAG: assert property ( // [R6]
    (ce && restart && ctl_q.wide_sample_select) |=>
      (cfg_q.mag == {$past(sample_q[6:0]), $past(ctl_q.low_bits)})
  ) else $error("Wide magnitude not formed from both registers.");

  AST_LAG_ONE_PERIOD: assert property ( // [R7]
    (ce && !restart) |=> (cfg_q == $past(cfg_q))
  ) else $error("Settings changed in mid period.");

  AST_PERIOD_LEN: assert property ( // [R8]
    (ce && wrap && full_q) |->
      (len_q == 10'(ppm_pkg::PERIOD_COUNTS *
                    int'(ppm_pkg::ppm_divisor(cfg_q.presc)) - 1))
  ) else $error("Sample period length is wrong.");

  AST_HIGH_LEN: assert property ( // [R10]
    (ce && wrap && full_q) |->
      ((hi_q + {9'h000, pos_q || neg_q}) == hi_expect(cfg_q))
  ) else $error("Pulse width does not match the magnitude.");

  AST_OFF_RELEASES: assert property ( // [R15]
    (ce && !ctl_q.on) |=> (!positive_pulse_oe && !negative_pulse_oe &&
                           !pos_q && !neg_q)
  ) else $error("Outputs still driven while off.");

  AST_BUS_ACK: assert property (
    (ce && bus_req && !ack_q) |=> (ack_q ##1 (!ack_q || !ce))
  ) else $error("Bus answer not given for exactly one cycle.");

  COV_NEG_PERIOD: cover property (
    ce && wrap && full_q && cfg_q.sign && cfg_q.mag != 9'h000
  );

  COV_WIDE_DIV4: cover property (
    ce && wrap && full_q && cfg_q.wide &&
    cfg_q.presc == ppm_pkg::PRESC_DIV4
  );

  COV_SATURATED: cover property (
    ce && wrap && full_q && cfg_q.wide && hi_q == len_q
  );

  COV_TURN_OFF: cover property (
    running ##1 !running
  );

endmodule : ppm_modulator

//--- test/ppm_speaker.sv
`timescale 1ns/100ps
// ============================================================
// Speaker across the two pulse outputs
// ============================================================
module ppm_speaker (
  input  wire logic        clk,
  input  wire logic        clear,
  input  wire logic        pos_out,
  input  wire logic        pos_oe,
  input  wire logic        neg_out,
  input  wire logic        neg_oe,
  output logic             pos_pin,
  output logic             neg_pin,
  output logic [15:0]      pos_high,
  output logic [15:0]      neg_high
);
  // A released pin floats up through its pull-up resistor.
  assign pos_pin = pos_oe ? pos_out : 1'b1;
  assign neg_pin = neg_oe ? neg_out : 1'b1;

  // ============================================================
  // High time tally
  // ============================================================
  // Counting per window avoids any need to find the period start.
  always_ff @(posedge clk) begin
    if (clear) begin
      pos_high <= 16'h0000;
      neg_high <= 16'h0000;
    end else begin
      pos_high <= pos_high + 16'(pos_pin);
      neg_high <= neg_high + 16'(neg_pin);
    end
  end
endmodule : ppm_speaker

//--- test/ppm_modulator_tb.sv
`timescale 1ns/100ps
// ============================================================
// Register and pulse output bench
// ============================================================
module ppm_modulator_tb;
  logic                 clk;
  logic                 reset;
  logic                 ce;
  logic                 clear;
  ppm_pkg::ppm_wb_req_t wb_req;
  ppm_pkg::ppm_wb_rsp_t wb_rsp;
  logic                 pos_out;
  logic                 pos_oe;
  logic                 neg_out;
  logic                 neg_oe;
  logic                 pos_pin;
  logic                 neg_pin;
  logic [15:0]          pos_high;
  logic [15:0]          neg_high;
  int                   miscompares;
  int                   comparisons;
  logic [7:0]           rd;

  // Control and sample pairs; each is held for several periods.
  localparam logic [15:0] CASES [11] = '{16'h0101, 16'h057F, 16'h0981,
    16'h0D7F, 16'h0100, 16'h0180, 16'h6100, 16'hE17F, 16'hE96F,
    16'hE57F, 16'hE5DF};

  ppm_modulator u_ppm_modulator (
    .clk                (clk),
    .reset              (reset),
    .ce                 (ce),
    .wb_req             (wb_req),
    .wb_rsp             (wb_rsp),
    .positive_pulse_out (pos_out),
    .positive_pulse_oe  (pos_oe),
    .negative_pulse_out (neg_out),
    .negative_pulse_oe  (neg_oe)
  );

  ppm_speaker u_ppm_speaker (
    .clk      (clk),
    .clear    (clear),
    .pos_out  (pos_out),
    .pos_oe   (pos_oe),
    .neg_out  (neg_out),
    .neg_oe   (neg_oe),
    .pos_pin  (pos_pin),
    .neg_pin  (neg_pin),
    .pos_high (pos_high),
    .neg_high (neg_high)
  );

  always #5 clk = ~clk;

  // ============================================================
  // Tasks
  // ============================================================
  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wb_cycle(input logic we, input logic [9:0] idx,
                          input logic [7:0] wdat, output logic [7:0] rdat);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00},
                sel: 4'hF, dat: {24'h000000, wdat}};
    @(posedge clk);
    while (wb_rsp.ack !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) begin
      miscompares++;
    end
    rdat = wb_rsp.dat[7:0];
    wb_req <= '0;
    @(posedge clk);
  endtask : wb_cycle

  task automatic wb_read(input logic [9:0] idx, input logic [7:0] exp,
                         input string what);
    logic [7:0] d;
    wb_cycle(1'b0, idx, 8'h00, d);
    check(what, {8'h00, exp}, {8'h00, d});
  endtask : wb_read

  // Expected high time is reckoned from the settings, then capped.
  task automatic run_case(input logic [7:0] ctl, input logic [7:0] smp);
    int div;
    int per;
    int mag;
    int hi;
    div = (ctl[3:2] == 2'h0) ? 4 : (ctl[3:2] == 2'h1) ? 6 : 7;
    per = 128 * div;
    mag = ctl[5] ? int'({smp[6:0], ctl[7:6]}) : int'(smp[6:0]);
    hi = !ctl[5] ? mag * div : (div == 4) ? mag : 2 * mag;
    if (hi > per) begin
      hi = per;
    end
    // Writes land once per case, well apart from the period edges.
    wb_cycle(1'b1, ppm_pkg::IDX_SAMPLE, smp, rd);
    wb_cycle(1'b1, ppm_pkg::IDX_CONTROL, ctl, rd);
    repeat (2 * per + 8) @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    repeat (per + 1) @(posedge clk);
    check("positive high", smp[7] ? 16'h0000 : 16'(hi), pos_high);
    check("negative high", smp[7] ? 16'(hi) : 16'h0000, neg_high);
  endtask : run_case

  task automatic print_verdict;
    $display("Comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // ============================================================
  // Main sequence
  // ============================================================
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    clear = 1'b0;
    wb_req = '0;
    miscompares = 0;
    comparisons = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    wb_read(ppm_pkg::IDX_CONTROL, ppm_pkg::CONTROL_RESET, "control");
    wb_read(ppm_pkg::IDX_SAMPLE, ppm_pkg::SAMPLE_RESET, "sample");
    wb_cycle(1'b1, 10'h0DA, 8'h5A, rd);
    wb_read(10'h0DA, 8'h00, "unmapped");
    check("positive pin off", 16'h0001, {15'h0000, pos_pin});
    check("negative pin off", 16'h0001, {15'h0000, neg_pin});
    wb_cycle(1'b1, ppm_pkg::IDX_CONTROL, 8'hFF, rd);
    wb_read(ppm_pkg::IDX_CONTROL, 8'hED, "control mask");
    wb_cycle(1'b1, ppm_pkg::IDX_SAMPLE, 8'hA5, rd);
    wb_read(ppm_pkg::IDX_SAMPLE, 8'hA5, "sample readback");
    // The divide-by-7 wide case stays within plus or minus 447.
    for (int i = 0; i < 11; i++) begin
      run_case(CASES[i][15:8], CASES[i][7:0]);
    end
    // The modulator is switched off before any chip power-down.
    wb_cycle(1'b1, ppm_pkg::IDX_CONTROL, 8'h00, rd);
    repeat (2) @(posedge clk);
    check("positive pin released", 16'h0001, {15'h0000, pos_pin});
    check("negative pin released", 16'h0001, {15'h0000, neg_pin});
    print_verdict();
  end

  initial begin
    #2000000;
    miscompares++;
    print_verdict();
  end
endmodule : ppm_modulator_tb
